// ### design/aid_diag.sv
/*
 Diagnostic reporting of an eight-channel analog input module: error
 substitution into measuring values, group error indicator, coming and
 going diagnostic interrupts, lost process interrupt detection and the
 4/16-byte diagnostic records read bytewise by the CPU side.
 Assumes channel status, samples, configuration and handshakes come from
 logic on i_clk; only the external supply sense is an asynchronous pin.
*/
`timescale 1ns/1ps
`include "aid_defines.svh"

module aid_diag
  import aid_pkg::*;
(
  input  wire logic                    i_clk,
  input  wire logic                    i_arst_n,
  input  wire aid_chan_stat_t [7:0]    i_chan_stat,
  input  wire aid_meas_t               i_raw,
  input  wire logic                    i_supply_ok_pin,
  input  wire logic                    i_diag_en,
  input  wire logic                    i_osc_mode,
  input  wire logic                    i_proc_req,
  input  wire logic                    i_proc_ack,
  input  wire logic                    i_diag_ack,
  input  wire aid_rec_req_t            i_rec,
  output logic                         o_diag_irq,
  output logic                         o_diag_coming,
  output logic                         o_proc_irq,
  output logic                         o_group_err,
  output aid_meas_t                    o_meas,
  output logic [7:0]                   o_rec_data,
  output logic                         o_rec_valid
);

  //////////////////////////////////////////////////////////////////////////
  // Declarations

  logic                   supply_meta;
  logic                   supply_ok;
  logic                   ext_missing;
  logic                   lost;
  logic [`AID_NCH-1:0]    chan_err;
  logic [`AID_NCH-1:0]    par_err;
  logic [`AID_NCH-1:0]    under;
  logic [`AID_NCH-1:0]    over;
  logic [`AID_ERRW-1:0]   err_vec;
  logic [`AID_ERRW-1:0]   act_err;
  logic [`AID_ERRW-1:0]   reported;
  logic                   err_change;
  logic                   new_err;
  aid_rec_t               live;
  aid_rec_t               snap;
  aid_state_t             state;

  function automatic logic any_fault(input aid_chan_stat_t s);
    any_fault = s.param_err | s.underflow | s.overflow;
  endfunction

  // Set here so the per-channel checks in the generate loop see them too
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);

  //////////////////////////////////////////////////////////////////////////
  // Supply sense synchroniser; reset assumes supply present

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      supply_meta <= 1'b1;
      supply_ok   <= 1'b1;
    end else begin
      supply_meta <= i_supply_ok_pin;
      supply_ok   <= supply_meta;
    end
  end

  assign ext_missing = ~supply_ok;

  //////////////////////////////////////////////////////////////////////////
  // Per-channel substitution and detail bytes

  genvar c;
  generate
    for (c = 0; c < `AID_NCH; c++) begin : g_ch
      assign chan_err[c] = any_fault(i_chan_stat[c]);
      assign par_err[c]  = i_chan_stat[c].param_err;
      assign under[c]    = i_chan_stat[c].underflow;
      assign over[c]     = i_chan_stat[c].overflow;

      always_comb begin
        live[`AID_OFS_DETAIL0+c] = 8'h00;
        live[`AID_OFS_DETAIL0+c][`AID_DT_PARAM] = par_err[c];
        live[`AID_OFS_DETAIL0+c][`AID_DT_UNDER] = under[c];
        live[`AID_OFS_DETAIL0+c][`AID_DT_OVER]  = over[c];
      end

      // Overflow class wins: a channel flagged both ways reads as overflow
      always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
          o_meas[c] <= 16'h0000;
        end else if (over[c] | par_err[c] | ext_missing) begin
          o_meas[c] <= `AID_CODE_OVER;
        end else if (under[c]) begin
          o_meas[c] <= `AID_CODE_UNDER;
        end else begin
          o_meas[c] <= i_raw[c];
        end
      end

      a_meas_over_code: assert property (
        (over[c] | par_err[c] | ext_missing) |=> o_meas[c] == `AID_CODE_OVER)
        else $error("Overflow code missing");
      a_meas_under_code: assert property (
        (under[c] & ~over[c] & ~par_err[c] & ~ext_missing)
          |=> o_meas[c] == `AID_CODE_UNDER)
        else $error("Underflow code missing");
      a_detail_byte_map: assert property (
        live[`AID_OFS_DETAIL0+c] == {over[c], under[c], 5'h00, par_err[c]})
        else $error("Channel detail byte wrong");
      a_meas_raw_pass: assert property (
        !(over[c] | under[c] | par_err[c] | ext_missing)
          |=> o_meas[c] == $past(i_raw[c]))
        else $error("Raw value not passed through");
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////
  // Live record contents

  always_comb begin
    live[`AID_OFS_SUMMARY] = 8'h00;
    live[`AID_OFS_SUMMARY][`AID_B0_MODULE]   = |err_vec;
    live[`AID_OFS_SUMMARY][`AID_B0_INTERNAL] = lost;
    live[`AID_OFS_SUMMARY][`AID_B0_EXTERNAL] = ext_missing | (|over) | (|under);
    live[`AID_OFS_SUMMARY][`AID_B0_CHANNEL]  = |chan_err;
    live[`AID_OFS_SUMMARY][`AID_B0_SUPPLY]   = ext_missing;
    live[`AID_OFS_SUMMARY][`AID_B0_PARAM]    = |par_err;
    live[`AID_OFS_CLASS]  = `AID_RST_CLASS;
    live[`AID_OFS_RSVD]   = `AID_RST_RSVD;
    live[`AID_OFS_LOST]   = 8'h00;
    live[`AID_OFS_LOST][`AID_B3_LOST] = lost;
    // Single channel type on this module, so the more-types bit stays 0
    live[`AID_OFS_CHTYPE] = `AID_RST_CHTYPE;
    live[`AID_OFS_BITS]   = `AID_RST_BITS;
    live[`AID_OFS_COUNT]  = `AID_RST_COUNT;
    live[`AID_OFS_CHERR]  = chan_err;
  end

  //////////////////////////////////////////////////////////////////////////
  // Process interrupt and lost detection

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_proc_irq <= 1'b0;
    end else if (i_osc_mode) begin
      o_proc_irq <= 1'b0;
    end else if (i_proc_req & ~o_proc_irq) begin
      o_proc_irq <= 1'b1;
    end else if (i_proc_ack) begin
      o_proc_irq <= 1'b0;
    end
  end

  // A request while the previous one is still pending is lost; the flag
  // clears once a diagnostic carrying it is acknowledged, set wins.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      lost <= 1'b0;
    end else if (~i_osc_mode & i_proc_req & o_proc_irq & ~i_proc_ack) begin
      lost <= 1'b1;
    end else if (i_diag_ack & o_diag_irq & snap[`AID_OFS_LOST][`AID_B3_LOST]) begin
      lost <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Diagnostic interrupt sequencing

  assign err_vec    = {ext_missing, lost, par_err, under, over};
  assign act_err    = i_diag_en ? err_vec : {`AID_ERRW{1'b0}};
  assign err_change = (state == AID_ST_IDLE) && (act_err != reported);
  assign new_err    = |(act_err & ~reported);

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state         <= AID_ST_IDLE;
      reported      <= {`AID_ERRW{1'b0}};
      o_diag_irq    <= 1'b0;
      o_diag_coming <= 1'b0;
    end else begin
      unique case (state)
        AID_ST_IDLE: begin
          if (err_change) begin
            state         <= AID_ST_RAISE;
            reported      <= act_err;
            o_diag_irq    <= 1'b1;
            o_diag_coming <= new_err;
          end
        end
        AID_ST_RAISE: begin
          if (i_diag_ack) begin
            state      <= AID_ST_IDLE;
            o_diag_irq <= 1'b0;
          end
        end
      endcase
    end
  end

  // Record stays frozen while the CPU services the interrupt so that all
  // bytes it reads belong to one event.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      snap[`AID_OFS_SUMMARY] <= `AID_RST_SUMMARY;
      snap[`AID_OFS_CLASS]   <= `AID_RST_CLASS;
      snap[`AID_OFS_RSVD]    <= `AID_RST_RSVD;
      snap[`AID_OFS_LOST]    <= `AID_RST_LOST;
      snap[`AID_OFS_CHTYPE]  <= `AID_RST_CHTYPE;
      snap[`AID_OFS_BITS]    <= `AID_RST_BITS;
      snap[`AID_OFS_COUNT]   <= `AID_RST_COUNT;
      snap[`AID_OFS_CHERR]   <= `AID_RST_CHERR;
      for (int i = `AID_OFS_DETAIL0; i <= `AID_OFS_DETAIL7; i++) begin
        snap[i] <= `AID_RST_DETAIL;
      end
    end else if (state == AID_ST_IDLE) begin
      snap <= live;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Group error indicator and record read port

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_group_err <= 1'b0;
    end else begin
      o_group_err <= i_diag_en & (|err_vec);
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rec_valid <= 1'b0;
      o_rec_data  <= 8'h00;
    end else begin
      o_rec_valid <= i_rec.rd;
      o_rec_data  <= i_rec.rd ? snap[i_rec.addr] : 8'h00;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Checks

  sequence s_err_rises;
    err_change && new_err;
  endsequence

  sequence s_err_falls;
    err_change && !new_err;
  endsequence

  sequence s_raised_coming;
    o_diag_irq && o_diag_coming;
  endsequence

  sequence s_raised_going;
    o_diag_irq && !o_diag_coming;
  endsequence

  property p_coming;
    s_err_rises |=> s_raised_coming;
  endproperty

  property p_going;
    s_err_falls |=> s_raised_going;
  endproperty

  property p_held_until_ack;
    o_diag_irq && !i_diag_ack |=> o_diag_irq && $stable(snap);
  endproperty

  property p_read_byte(logic [3:0] a, logic [7:0] v);
    i_rec.rd && i_rec.addr == a |=> o_rec_valid && o_rec_data == v;
  endproperty

  a_diag_coming_raise: assert property (p_coming)
    else $error("Coming interrupt not raised");
  a_diag_going_raise: assert property (p_going)
    else $error("Going interrupt not raised");
  a_diag_disabled_quiet: assert property (
    !i_diag_en && state == AID_ST_IDLE && reported == '0 |=> !o_diag_irq)
    else $error("Interrupt raised while disabled");
  a_diag_irq_hold: assert property (p_held_until_ack)
    else $error("Record or interrupt dropped before ack");
  a_group_led_gate: assert property (
    i_diag_en && (|err_vec) |=> o_group_err)
    else $error("Group error indicator missing");
  a_group_led_off: assert property (!i_diag_en |=> !o_group_err)
    else $error("Group error lit while disabled");
  a_rec_class_byte: assert property (p_read_byte(`AID_OFS_CLASS, `AID_RST_CLASS))
    else $error("Module class byte wrong");
  a_rec_rsvd_byte: assert property (p_read_byte(`AID_OFS_RSVD, 8'h00))
    else $error("Reserved byte not zero");
  a_rec_type_byte: assert property (p_read_byte(`AID_OFS_CHTYPE, `AID_RST_CHTYPE))
    else $error("Channel type byte wrong");
  a_rec_bits_byte: assert property (p_read_byte(`AID_OFS_BITS, `AID_RST_BITS))
    else $error("Diagnostic bit count wrong");
  a_rec_count_byte: assert property (p_read_byte(`AID_OFS_COUNT, `AID_RST_COUNT))
    else $error("Channel count wrong");
  a_summary_layout: assert property (
    live[`AID_OFS_SUMMARY][6:5] == 2'b00 &&
    live[`AID_OFS_SUMMARY][`AID_B0_PARAM] == |par_err &&
    live[`AID_OFS_SUMMARY][`AID_B0_SUPPLY] == ext_missing)
    else $error("Summary byte layout wrong");
  a_chan_err_byte: assert property (live[`AID_OFS_CHERR] == chan_err)
    else $error("Channel error byte wrong");
  a_lost_flag_set: assert property (
    !i_osc_mode && i_proc_req && o_proc_irq && !i_proc_ack
      |=> lost ##0 live[`AID_OFS_LOST] == 8'h40)
    else $error("Lost interrupt not flagged");
  a_osc_no_proc: assert property (i_osc_mode |=> !o_proc_irq)
    else $error("Process interrupt in oscilloscope mode");
  a_basic_in_ext: assert property (
    state == AID_ST_IDLE |=> snap[`AID_BASIC_BYTES-1:0] == $past(live[`AID_BASIC_BYTES-1:0]))
    else $error("Basic record not mirrored");
  a_summary_module: assert property (
    live[`AID_OFS_SUMMARY][`AID_B0_MODULE] == |err_vec &&
    live[`AID_OFS_SUMMARY][`AID_B0_INTERNAL] == lost)
    else $error("Summary module or internal bit wrong");
  a_lost_byte_rsvd: assert property (
    live[`AID_OFS_LOST][5:0] == 6'h00 && !live[`AID_OFS_LOST][7])
    else $error("Reserved bit set in lost byte");
  // A fresh lost request in the ack cycle keeps the flag, so it is excluded
  a_lost_clear_ack: assert property (
    i_diag_ack && o_diag_irq && snap[`AID_OFS_LOST][`AID_B3_LOST] &&
    !(!i_osc_mode && i_proc_req && o_proc_irq && !i_proc_ack) |=> !lost)
    else $error("Lost flag not cleared by ack");
  a_diag_ack_drop: assert property (o_diag_irq && i_diag_ack |=> !o_diag_irq)
    else $error("Interrupt not withdrawn after ack");
  a_proc_irq_raise: assert property (
    !i_osc_mode && i_proc_req && !o_proc_irq |=> o_proc_irq)
    else $error("Process interrupt not raised");
  a_rec_idle_zero: assert property (
    !i_rec.rd |=> !o_rec_valid && o_rec_data == 8'h00)
    else $error("Record port not quiet between reads");

endmodule

// ### inc/aid_defines.svh
/*
 Constants of the analog input diagnostics block: record offsets, field
 positions, reset values and substitute codes. Assumes inclusion by the
 package and the design module only.
*/
`ifndef AID_DEFINES_SVH
`define AID_DEFINES_SVH

`define AID_NCH          8
`define AID_REC_BYTES    16
`define AID_BASIC_BYTES  4
`define AID_ERRW         26

`define AID_OFS_SUMMARY  4'h0
`define AID_OFS_CLASS    4'h1
`define AID_OFS_RSVD     4'h2
`define AID_OFS_LOST     4'h3
`define AID_OFS_CHTYPE   4'h4
`define AID_OFS_BITS     4'h5
`define AID_OFS_COUNT    4'h6
`define AID_OFS_CHERR    4'h7
`define AID_OFS_DETAIL0  4'h8
`define AID_OFS_DETAIL7  4'hF

`define AID_B0_MODULE    0
`define AID_B0_INTERNAL  1
`define AID_B0_EXTERNAL  2
`define AID_B0_CHANNEL   3
`define AID_B0_SUPPLY    4
`define AID_B0_PARAM     7
`define AID_B3_LOST      6
`define AID_DT_PARAM     0
`define AID_DT_UNDER     6
`define AID_DT_OVER      7

`define AID_RST_SUMMARY  8'h00
`define AID_RST_CLASS    8'h15
`define AID_RST_RSVD     8'h00
`define AID_RST_LOST     8'h00
`define AID_RST_CHTYPE   8'h71
`define AID_RST_BITS     8'h08
`define AID_RST_COUNT    8'h08
`define AID_RST_CHERR    8'h00
`define AID_RST_DETAIL   8'h00

`define AID_CODE_OVER    16'h7FFF
`define AID_CODE_UNDER   16'h8000

`endif

// ### inc/aid_pkg.sv
/*
 Types of the analog input diagnostics block. Assumes aid_defines.svh
 is on the include path.
*/
`include "aid_defines.svh"

package aid_pkg;

  typedef struct packed {
    logic param_err;
    logic underflow;
    logic overflow;
  } aid_chan_stat_t;

  typedef struct packed {
    logic       rd;
    logic [3:0] addr;
  } aid_rec_req_t;

  typedef logic [15:0]                  aid_sample_t;
  typedef logic [`AID_NCH-1:0][15:0]    aid_meas_t;
  typedef logic [`AID_REC_BYTES-1:0][7:0] aid_rec_t;

  typedef enum logic [1:0] {
    AID_ST_IDLE  = 2'b01,
    AID_ST_RAISE = 2'b10
  } aid_state_t;

endpackage

// ### tb/aid_cpu_model.sv
/*
 CPU side of the backplane: runs each interrupt handler for i_delay
 cycles, then leaves it with a one-cycle acknowledge.
 Assumes i_delay of at least 2, so one ack is given per request.
*/
`timescale 1ns/1ps

module aid_cpu_model (
  input  wire logic       i_clk,
  input  wire logic       i_arst_n,
  input  wire logic       i_diag_irq,
  input  wire logic       i_proc_irq,
  input  wire logic [7:0] i_delay,
  output logic            o_diag_ack,
  output logic            o_proc_ack
);
  logic [7:0] diag_cnt;
  logic [7:0] proc_cnt;

  ////////////////////////////////////////////////////////////////////
  // Counter restarts once the request drops, so a late ack never repeats
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      diag_cnt   <= 8'h00;
      o_diag_ack <= 1'b0;
    end else begin
      diag_cnt   <= (i_diag_irq && !o_diag_ack) ? diag_cnt + 8'h01 : 8'h00;
      o_diag_ack <= i_diag_irq && (diag_cnt == i_delay);
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      proc_cnt   <= 8'h00;
      o_proc_ack <= 1'b0;
    end else begin
      proc_cnt   <= (i_proc_irq && !o_proc_ack) ? proc_cnt + 8'h01 : 8'h00;
      o_proc_ack <= i_proc_irq && (proc_cnt == i_delay);
    end
  end
endmodule

// ### tb/aid_diag_tb.sv
/*
 Self-checking bench of the diagnostics block: table of channel cases,
 then interrupt, record freeze, scope mode, lost request and reset.
 Assumes the CPU model answers 30 cycles after each request.
*/
`timescale 1ns/1ps

module aid_diag_tb;
  import aid_pkg::*;

  typedef struct packed {
    logic [2:0]     ch;
    aid_chan_stat_t st;
    logic           sup;
    aid_sample_t    raw;
    aid_sample_t    meas;
  } aid_row_t;

  localparam aid_row_t ROWS [7] = '{
    '{3'h0, 3'h0, 1'b1, 16'h1234, 16'h1234},
    '{3'h1, 3'h1, 1'b1, 16'h0042, 16'h7FFF},
    '{3'h2, 3'h2, 1'b1, 16'h0042, 16'h8000},
    '{3'h3, 3'h4, 1'b1, 16'h0042, 16'h7FFF},
    '{3'h4, 3'h3, 1'b1, 16'h0042, 16'h7FFF},
    '{3'h7, 3'h0, 1'b0, 16'h0042, 16'h7FFF},
    '{3'h5, 3'h2, 1'b0, 16'h0042, 16'h7FFF}};
  localparam logic [7:0] DEF [16] = '{8'h00, 8'h15, 8'h00, 8'h00, 8'h71,
    8'h08, 8'h08, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

  logic                 i_clk = 1'b0;
  logic                 i_arst_n = 1'b0;
  aid_chan_stat_t [7:0] stat;
  aid_meas_t            raw;
  aid_meas_t            meas;
  aid_rec_req_t         rec;
  logic                 sup, diag_en, osc, proc_req, proc_ack, diag_ack;
  logic                 diag_irq, coming, proc_irq, group_err, rec_valid;
  logic [7:0]           rec_data;
  int                   failures;
  int                   checks_done;

  always #2.5 i_clk = ~i_clk;

  aid_diag uut (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_chan_stat(stat), .i_raw(raw),
    .i_supply_ok_pin(sup), .i_diag_en(diag_en), .i_osc_mode(osc), .i_proc_req(proc_req),
    .i_proc_ack(proc_ack), .i_diag_ack(diag_ack), .i_rec(rec), .o_diag_irq(diag_irq),
    .o_diag_coming(coming), .o_proc_irq(proc_irq), .o_group_err(group_err),
    .o_meas(meas), .o_rec_data(rec_data), .o_rec_valid(rec_valid));

  aid_cpu_model cpu (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_diag_irq(diag_irq),
    .i_proc_irq(proc_irq), .i_delay(8'h1E), .o_diag_ack(diag_ack), .o_proc_ack(proc_ack));

  ////////////////////////////////////////////////////////////////////
  task automatic summarize();
    if (failures == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Valid is looked at in the one cycle it stands
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(negedge i_clk);
    rec = '{1'b1, a};
    @(negedge i_clk);
    rec = '{1'b0, 4'h0};
    chk({7'h00, rec_valid, rec_data}, {8'h01, exp});
  endtask

  task automatic wait_irq(input logic lvl);
    int i;
    for (i = 0; i < 200 && diag_irq !== lvl; i++) @(negedge i_clk);
    if (diag_irq !== lvl) begin
      failures++;
      $display("CHECK FAILED %0t interrupt wait ran out", $time);
      summarize();
    end
  endtask

  task automatic pulse_req();
    @(negedge i_clk);
    proc_req = 1'b1;
    @(negedge i_clk);
    proc_req = 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////
  initial begin
    stat = '0;
    raw = '0;
    rec = '0;
    {sup, diag_en, osc, proc_req} = 4'b1000;
    failures = 0;
    checks_done = 0;
    repeat (2) @(negedge i_clk);
    chk({12'h0, diag_irq, proc_irq, group_err, rec_valid}, 16'h0);
    i_arst_n = 1'b1;
    for (int k = 0; k < 16; k++) rd(4'(k), DEF[k]);
    foreach (ROWS[r]) begin
      aid_row_t w;
      w = ROWS[r];
      stat = '0;
      stat[w.ch] = w.st;
      sup = w.sup;
      raw[w.ch] = w.raw;
      repeat (5) @(negedge i_clk);
      chk(meas[w.ch], w.meas);
      chk({14'h0, diag_irq, group_err}, 16'h0);
      rd(4'h8 + 4'(w.ch), {w.st.overflow, w.st.underflow, 5'h00, w.st.param_err});
      rd(4'h7, (|w.st) ? 8'h01 << w.ch : 8'h00);
      rd(4'h0, {w.st.param_err, 2'b00, ~w.sup, |w.st,
        ~w.sup | w.st.overflow | w.st.underflow, 1'b0, |w.st | ~w.sup});
    end
    stat = '0;
    sup = 1'b1;
    // Supply must read present again before enabling, else it reports first
    repeat (5) @(negedge i_clk);
    diag_en = 1'b1;
    repeat (5) @(negedge i_clk);
    chk({15'h0, diag_irq}, 16'h0);
    stat[2].overflow = 1'b1;
    wait_irq(1'b1);
    chk({14'h0, coming, group_err}, 16'h3);
    rd(4'hA, 8'h80);
    rd(4'h7, 8'h04);
    rd(4'h0, 8'h0D);
    // Record stays consistent until the handler leaves
    stat[5].underflow = 1'b1;
    rd(4'hD, 8'h00);
    wait_irq(1'b0);
    wait_irq(1'b1);
    chk({15'h0, coming}, 16'h1);
    rd(4'hD, 8'h40);
    stat = '0;
    wait_irq(1'b0);
    wait_irq(1'b1);
    chk({15'h0, coming}, 16'h0);
    wait_irq(1'b0);
    repeat (3) @(negedge i_clk);
    chk({15'h0, group_err}, 16'h0);
    osc = 1'b1;
    pulse_req();
    pulse_req();
    repeat (2) @(negedge i_clk);
    chk({15'h0, proc_irq}, 16'h0);
    rd(4'h3, 8'h00);
    osc = 1'b0;
    pulse_req();
    chk({15'h0, proc_irq}, 16'h1);
    pulse_req();
    wait_irq(1'b1);
    chk({15'h0, coming}, 16'h1);
    rd(4'h3, 8'h40);
    rd(4'h0, 8'h03);
    wait_irq(1'b0);
    wait_irq(1'b1);
    chk({15'h0, coming}, 16'h0);
    wait_irq(1'b0);
    stat[0].overflow = 1'b1;
    repeat (3) @(negedge i_clk);
    i_arst_n = 1'b0;
    @(negedge i_clk);
    chk({14'h0, diag_irq, group_err}, 16'h0);
    stat = '0;
    i_arst_n = 1'b1;
    rd(4'h1, 8'h15);
    summarize();
  end
endmodule
